// file: periodic_down_timer_pkg.sv
// package: constants and carrier types for the periodic down timer
package periodic_down_timer_pkg;
    localparam int          CLOCK_PERIOD_NS = 8;
    localparam int          TICK_PERIOD_US  = 100;
    localparam int          TICK_CYCLES     = (TICK_PERIOD_US * 1000) / CLOCK_PERIOD_NS;
    localparam logic [15:0] COUNT_RESET     = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO      = 16'h0000;

    // software-side register writes and enables
    typedef struct packed {
        logic        runEnable;
        logic        irqEnable;
        logic        preloadWrite;
        logic [15:0] preloadData;
        logic        flagClear;
    } timer_ctrl_t;

    // timer state shown to software
    typedef struct packed {
        logic [15:0] timerCount;
        logic [15:0] preloadValue;
        logic        timerWrapFlag;
        logic        hostIrq;
    } timer_stat_t;
endpackage

// file: periodic_down_timer.sv
// module: 16-bit periodic down timer with sticky wrap flag and host interrupt
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - each decrement of the count happens once per 100 microsecond tick.
// - setting run enable loads preload into count, then counting down starts.
// - reset or run enable falling forces the count to FFFFh.
// - preload value may be written at any time regardless of run enable.
// - while enabled count decrements; a preload write restarts from the new value.
// - at 0000h count wraps to FFFFh, sets wrap flag, keeps counting.
// - wrap flag and interrupt only set when interrupt enable is set at wrap.
// - wrap flag is sticky; writing one clears it, zero leaves it.
module periodic_down_timer #(
    parameter int TICK_CYCLES = periodic_down_timer_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                                clock,
    input  wire logic                                reset,
    // software controls
    input  wire periodic_down_timer_pkg::timer_ctrl_t ctrl,
    // software-visible state
    output var  periodic_down_timer_pkg::timer_stat_t stat
);
    // prescaler width; a one-cycle tick still needs a bit of state
    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic [TW-1:0] tickCount_q;
    logic [TW-1:0] tickCount_d;
    logic [15:0]   count_q;
    logic [15:0]   count_d;
    logic [15:0]   preload_q;
    logic [15:0]   preload_d;
    logic          runEnable_q;
    logic          flag_q;
    logic          flag_d;
    logic          irq_q;
    logic          irq_d;
    wire           tick;
    wire           rise;
    wire           fall;
    wire           wrap;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // one step down of a count value; the wrap at zero is decided by the caller
    function automatic logic [15:0] stepDown(input logic [15:0] value);
        return value - 16'h0001;
    endfunction

    // a count value that has reached the terminal value
    function automatic logic atZero(input logic [15:0] value);
        return value == periodic_down_timer_pkg::COUNT_ZERO;
    endfunction

    // ---------------------------------------------------------------
    // tick prescaler and enable edges
    // ---------------------------------------------------------------
    assign tick = runEnable_q && (tickCount_q == TW'(TICK_CYCLES - 1));
    // run enable edges, seen against last cycle's level
    assign rise = ctrl.runEnable && !runEnable_q;
    assign fall = !ctrl.runEnable && runEnable_q;
    // a tick at zero wraps, unless there is a preload write in that cycle, running or not
    assign wrap = tick && atZero(count_q) && !ctrl.preloadWrite;
    // prescaler restarts whenever counting is (re)started
    assign tickCount_d = (!runEnable_q || rise || ctrl.preloadWrite || tick) ? '0 : tickCount_q + TW'(1);

    // ---------------------------------------------------------------
    // count and preload next values
    // ---------------------------------------------------------------
    assign preload_d = ctrl.preloadWrite ? ctrl.preloadData : preload_q;
    // priority of count updates, highest first:
    //   run enable falling forces FFFFh
    //   enable rising, or a preload write while running, loads the preload
    //   a tick at zero wraps round to FFFFh
    //   any other tick steps the count down by one
    // a preload write in the wrap cycle wins, so no flag is raised then;
    // a preload write while stopped only stores the value
    assign count_d = fall ? periodic_down_timer_pkg::COUNT_RESET
                   : (rise || (ctrl.runEnable && ctrl.preloadWrite)) ? preload_d
                   : wrap ? periodic_down_timer_pkg::COUNT_RESET
                   : tick ? stepDown(count_q)
                   : count_q;
    // set wins over a same-cycle clear
    assign flag_d = (wrap && ctrl.irqEnable) || (flag_q && !ctrl.flagClear);
    // interrupt follows flag and enable; a masked flag stays set for polling
    assign irq_d  = flag_d && ctrl.irqEnable;

    // state registers
    always_ff @(posedge clock) begin
        if (reset) begin
            tickCount_q <= '0;
            count_q     <= periodic_down_timer_pkg::COUNT_RESET;
            preload_q   <= periodic_down_timer_pkg::COUNT_RESET;
            runEnable_q <= 1'b0;
            flag_q      <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            tickCount_q <= tickCount_d;
            count_q     <= count_d;
            preload_q   <= preload_d;
            runEnable_q <= ctrl.runEnable;
            flag_q      <= flag_d;
            irq_q       <= irq_d;
        end
    end

    // outputs straight from flops
    assign stat.timerCount    = count_q;
    assign stat.preloadValue  = preload_q;
    assign stat.timerWrapFlag = flag_q;
    assign stat.hostIrq       = irq_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // an enable rise, the first step of a load
    sequence enableRise;
        ctrl.runEnable && !runEnable_q;
    endsequence

    chk_enable_loads: assert property (@(posedge clock) disable iff (reset)
        enableRise ##1 1'b1 |-> count_q == $past(preload_d)) else $error("count not loaded on enable");
    chk_disable_resets: assert property (@(posedge clock) disable iff (reset)
        fall |=> count_q == periodic_down_timer_pkg::COUNT_RESET) else $error("count not FFFF on disable");
    chk_preload_any: assert property (@(posedge clock) disable iff (reset)
        ctrl.preloadWrite |=> preload_q == $past(ctrl.preloadData)) else $error("preload write lost");
    chk_tick_decrement: assert property (@(posedge clock) disable iff (reset)
        (tick && !wrap && !fall && !ctrl.preloadWrite) |=> count_q == stepDown($past(count_q)))
        else $error("count did not decrement on tick");
    chk_idle_hold: assert property (@(posedge clock) disable iff (reset)
        (!tick && !fall && !rise && !ctrl.preloadWrite) |=> $stable(count_q)) else $error("count moved without tick");
    chk_wrap_reload: assert property (@(posedge clock) disable iff (reset)
        (wrap && !fall) |=> count_q == periodic_down_timer_pkg::COUNT_RESET) else $error("no wrap to FFFF");
    chk_flag_gated: assert property (@(posedge clock) disable iff (reset)
        (!flag_q && !(wrap && ctrl.irqEnable)) |=> !flag_q) else $error("flag set without enabled wrap");
    chk_flag_sticky: assert property (@(posedge clock) disable iff (reset)
        (flag_q && !ctrl.flagClear) |=> flag_q) else $error("flag dropped without clear");
    chk_irq_follows: assert property (@(posedge clock) disable iff (reset)
        irq_q == (flag_q && $past(ctrl.irqEnable))) else $error("irq does not track flag and enable");

    // ---------------------------------------------------------------
    // checker helper: how long the count stood before each step
    // ---------------------------------------------------------------
    localparam int CW = TW + 1;

    logic [15:0]   lastCount_q;
    logic          restartSeen_q;
    logic [CW-1:0] standCycles_q;
    logic [CW-1:0] standCycles_d;
    wire           restart;
    wire           stepSeen;

    // the count is loaded this cycle, by an enable rise or a running preload write
    assign restart  = ctrl.runEnable && (!runEnable_q || ctrl.preloadWrite);
    // the last edge moved the count one down, or from zero round to FFFFh
    assign stepSeen = (count_q == stepDown(lastCount_q))
                   || (atZero(lastCount_q) && count_q == periodic_down_timer_pkg::COUNT_RESET);
    // edges since the count last changed or was loaded, held at its top value
    assign standCycles_d = (restartSeen_q || count_q != lastCount_q) ? CW'(1)
                         : (&standCycles_q) ? standCycles_q
                         : standCycles_q + CW'(1);

    // helper registers, cleared with the design
    always_ff @(posedge clock) begin
        if (reset) begin
            lastCount_q   <= periodic_down_timer_pkg::COUNT_RESET;
            restartSeen_q <= 1'b0;
            standCycles_q <= '0;
        end else begin
            lastCount_q   <= count_q;
            restartSeen_q <= restart;
            standCycles_q <= standCycles_d;
        end
    end

    // a running step comes exactly one tick period after the previous change
    chk_tick_period: assert property (@(posedge clock) disable iff (reset)
        (stepSeen && runEnable_q && !restartSeen_q) |-> standCycles_q == CW'(TICK_CYCLES))
        else $error("count step not one tick period after the last change");
    // the prescaler never runs past the end of its period
    chk_prescaler_bound: assert property (@(posedge clock) disable iff (reset)
        tickCount_q <= TW'(TICK_CYCLES - 1)) else $error("prescaler ran past its period");
    // a running preload write restarts the count from the written value
    chk_preload_restart: assert property (@(posedge clock) disable iff (reset)
        (ctrl.runEnable && runEnable_q && ctrl.preloadWrite) |=> count_q == $past(ctrl.preloadData))
        else $error("running preload write did not restart count");
    // reset leaves the count at FFFFh and the flag and interrupt low
    chk_reset_values: assert property (@(posedge clock)
        reset |=> (count_q == periodic_down_timer_pkg::COUNT_RESET && !flag_q && !irq_q))
        else $error("reset values not applied");

    // ---------------------------------------------------------------
    // flag and interrupt steps
    // ---------------------------------------------------------------
    // a wrap that is allowed to raise the flag
    sequence armedWrap;
        wrap && ctrl.irqEnable;
    endsequence

    // a clearing write with no raising wrap beside it
    sequence plainClear;
        ctrl.flagClear && !(wrap && ctrl.irqEnable);
    endsequence

    // the flag and the interrupt standing together
    sequence flagAndIrq;
        flag_q && irq_q;
    endsequence

    // an armed wrap raises both, even against a same-cycle clear
    chk_wrap_raises: assert property (@(posedge clock) disable iff (reset)
        armedWrap |=> flagAndIrq) else $error("armed wrap did not raise flag and interrupt");
    // a clearing write drops the flag and the interrupt
    chk_clear_drops: assert property (@(posedge clock) disable iff (reset)
        plainClear |=> (!flag_q && !irq_q)) else $error("clearing write left flag or interrupt set");
    // a masked interrupt stays low
    chk_irq_masked: assert property (@(posedge clock) disable iff (reset)
        !ctrl.irqEnable |=> !irq_q) else $error("interrupt set while masked");
    // the interrupt never stands without the flag
    chk_irq_has_flag: assert property (@(posedge clock) disable iff (reset)
        irq_q |-> flag_q) else $error("interrupt without wrap flag");
endmodule
`default_nettype wire

// file: host_isr_model.sv
// host software model: writes one to the wrap flag when the interrupt shows
`timescale 1ns/1ns
`default_nettype none
module host_isr_model (
    // clock
    input  wire logic clock,
    // interrupt seen, clear pulse sent
    input  wire logic ackEnable,
    input  wire logic hostIrq,
    output var  logic flagClear
);
    // one-cycle clear pulse, launched at the falling edge
    initial flagClear = 1'b0;
    always @(negedge clock) begin
        flagClear <= ackEnable && hostIrq && !flagClear;
    end
endmodule
`default_nettype wire

// file: testbench.sv
// testbench for the periodic down timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                                 clock = 0, reset = 1, ackOn = 0, hostClr;
    periodic_down_timer_pkg::timer_ctrl_t ctl = '0, ctrl;
    periodic_down_timer_pkg::timer_stat_t stat;
    int                                   errCount = 0, checked = 0, cycles = 0, n;
    always #4 clock = ~clock;
    // host clear pulses join the bench's own writes
    assign ctrl = '{ctl.runEnable, ctl.irqEnable, ctl.preloadWrite, ctl.preloadData, ctl.flagClear | hostClr};
    periodic_down_timer #(.TICK_CYCLES(4)) periodic_down_timer_i (
        .clock(clock), .reset(reset), .ctrl(ctrl), .stat(stat));
    host_isr_model host_isr_model_i (.clock(clock), .ackEnable(ackOn), .hostIrq(stat.hostIrq), .flagClear(hostClr));
    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle preload write
    task automatic load(input logic [15:0] d);
        ctl.preloadData = d;
        ctl.preloadWrite = 1'b1;
        tick(1);
        ctl.preloadWrite = 1'b0;
    endtask
    // follow the count down through zero; n ends as the last step length
    task automatic wrapFrom(input int s);
        for (int v = s; v >= 0; v--) begin
            n = 0;
            while (stat.timerCount === 16'(v) && n < 50) begin
                tick(1);
                n++;
            end
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errCount++;
            close_out();
        end
    end
    initial begin
        tick(16);
        reset = 1'b0;
        chk("count", stat.timerCount, 16'hFFFF);
        chk("preload", stat.preloadValue, 16'hFFFF);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0000);
        load(16'h0003);
        chk("preload", stat.preloadValue, 16'h0003);
        chk("count", stat.timerCount, 16'hFFFF);
        $display("test done: reset and idle load");
        ctl.irqEnable = 1'b1;
        ctl.runEnable = 1'b1;
        tick(1);
        chk("count", stat.timerCount, 16'h0003);
        wrapFrom(3);
        chk("tick", 16'(n), 16'h0004);
        chk("count", stat.timerCount, 16'hFFFF);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0003);
        tick(6);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0003);
        ackOn <= 1'b1;
        tick(3);
        ackOn <= 1'b0;
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0000);
        $display("test done: run, wrap and clear");
        ctl.irqEnable = 1'b0;
        load(16'h0002);
        chk("count", stat.timerCount, 16'h0002);
        wrapFrom(2);
        chk("count", stat.timerCount, 16'hFFFF);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0000);
        tick(5);
        chk("count", stat.timerCount, 16'hFFFE);
        ctl.runEnable = 1'b0;
        tick(1);
        chk("count", stat.timerCount, 16'hFFFF);
        $display("test done: reload, masked wrap, stop");
        ctl.irqEnable = 1'b1;
        ctl.runEnable = 1'b1;
        tick(1);
        wrapFrom(2);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0003);
        ctl.irqEnable = 1'b0;
        tick(1);
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0002);
        ctl.irqEnable = 1'b1;
        ctl.flagClear = 1'b1;
        tick(1);
        ctl.flagClear = 1'b0;
        chk("flags", {14'h0000, stat.timerWrapFlag, stat.hostIrq}, 16'h0000);
        $display("test done: masking and software clear");
        close_out();
    end
endmodule
`default_nettype wire
